/* shared/iad_defines.svh */
// Offsets, field positions, reset values and fixed constants of the arithmetic datapath.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef IAD_DEFINES_SVH
`define IAD_DEFINES_SVH
// Register byte offsets (general registers I..T at index * 4)
`define IAD_OFF_MEM 8'h18
`define IAD_OFF_PC 8'h1C
`define IAD_OFF_CMD 8'h20
`define IAD_OFF_STATUS 8'h24
`define IAD_OFF_FAULT 8'h28
`define IAD_OFF_IMM 8'h2C
`define IAD_NUM_GPR 6
// Command word fields
`define IAD_CMD_OP_LSB 0
`define IAD_CMD_SEL_LSB 4
`define IAD_CMD_CNT_LSB 8
`define IAD_CMD_SRC_LSB 16
`define IAD_CMD_DST_LSB 24
// Status word fields
`define IAD_ST_BUSY 0
`define IAD_ST_CC_LSB 1
`define IAD_ST_OV 3
`define IAD_ST_PCDEC 4
// Fault word fields
`define IAD_FLT_DEMAND 0
`define IAD_FLT_RESTRICT 1
`define IAD_FLT_LIMIT 2
`define IAD_FLT_USER 3
// General register indices
`define IAD_IDX_I 3'd0
`define IAD_IDX_E 3'd3
`define IAD_IDX_A 3'd4
`define IAD_IDX_T 3'd5
// Condition code values
`define IAD_CC_ZERO 2'h0
`define IAD_CC_POS 2'h1
`define IAD_CC_NEG 2'h2
// Reset values and fixed patterns
`define IAD_RST_WORD 24'h000000
`define IAD_FULL_NEG 24'h800000
`define IAD_NORM_STOP 24'hC00000
`define IAD_NORM_ZERO_COUNT 24'hFFFF81
`endif

/* shared/iad_pkg.sv */
// Types of the arithmetic datapath: operations, sequencer states, state record.
// Assumes iad_defines.svh for widths of the record.
`include "iad_defines.svh"
package iad_pkg;
  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_add_imm_to_reg = 4'h1,
    op_add_imm_to_mem = 4'h2,
    op_add_reg_to_reg = 4'h3,
    op_divide_by_mem = 4'h4,
    op_divide_by_imm = 4'h5,
    op_divide_by_index = 4'h6,
    op_divide_by_t = 4'h7,
    op_poly_divide = 4'h8,
    op_sign_extend_a = 4'h9,
    op_sign_extend_byte = 4'hA,
    op_float_normalize = 4'hB,
    op_multiply_by_mem = 4'hC,
    op_multiply_by_imm = 4'hD,
    op_multiply_by_reg = 4'hE
  } iad_op_t;

  typedef enum logic [1:0] {
    fsm_idle = 2'b00,
    fsm_poly = 2'b01,
    fsm_norm = 2'b10
  } iad_fsm_t;

  typedef struct packed {
    logic [`IAD_NUM_GPR-1:0][23:0] gpr;
    logic [23:0] mem;
    logic [23:0] pc;
    logic [14:0] imm;
    logic [3:0] fault;
    logic [1:0] cc;
    logic ov;
    logic pcdec;
    iad_fsm_t fsm;
    logic [7:0] steps;
    logic [23:0] nshift;
    logic [31:0] rdata;
  } iad_state_t;
endpackage

/* hw/iad_datapath.sv */
// Integer arithmetic datapath: adds, divides, polynomial divide, extends, normalize, multiply.
// Assumes an APB master on pclk; operands and results live in the APB-visible registers.
//
// Contract
// - Add 15-bit immediate into selected register
// - Register codes 1..6 select I,J,K,E,A,T
// - Adds set condition code and carry overflow
// - Add signed 8-bit immediate into memory word
// - User-mode access violation decrements program counter
// - Register add uses source/destination bit masks, one bit per register
// - Masked sources ORed; only flagged destinations written
// - Divide clears A23; quotient A, remainder E
// - Remainder takes dividend sign; cc from quotient
// - Divide overflows when E reaches divisor
// - Divisor from I/J/K or fixed T
// - Immediate divide uses 15-bit unsigned divisor
// - Modulo-2 divide E by A, A kept
// - Zero shift count acts as one
// - Extend A sign into E, clear A23
// - Extend byte sign, cc from A
// - Normalize left until E22 differs E23
// - Stop at 1100..0; fix 1000..0 right
// - Zero double register gives fixed count
// - Preset overflow: shift right, count one, flip sign
// - Signed multiply A into double register
// - Full-scale negative squared sets overflow
`timescale 1ns/1ps
`include "iad_defines.svh"
module iad_datapath (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  iad_pkg::iad_state_t st_reg;
  iad_pkg::iad_state_t st_next;

  // Decoded command fields, taken straight from the bus word
  iad_pkg::iad_op_t c_op;
  logic [2:0] c_sel;
  logic [2:0] sel_idx;
  logic sel_ok;
  logic [7:0] c_cnt;
  logic [5:0] c_src;
  logic [5:0] c_dst;
  assign c_op = iad_pkg::iad_op_t'(pwdata[`IAD_CMD_OP_LSB +: 4]);
  assign c_sel = pwdata[`IAD_CMD_SEL_LSB +: 3];
  assign c_cnt = pwdata[`IAD_CMD_CNT_LSB +: 8];
  assign c_src = pwdata[`IAD_CMD_SRC_LSB +: 6];
  assign c_dst = pwdata[`IAD_CMD_DST_LSB +: 6];
  assign sel_idx = c_sel - 3'd1;
  assign sel_ok = (c_sel != 3'd0) && (c_sel != 3'd7);

  // APB phases; the slave never stalls
  logic busy;
  logic acc;
  logic acc_wr;
  logic go;
  logic mapped;
  assign busy = st_reg.fsm != iad_pkg::fsm_idle;
  assign acc = psel && penable;
  assign acc_wr = acc && pwrite && mapped && !busy;
  assign go = acc_wr && (paddr == `IAD_OFF_CMD);
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `IAD_OFF_IMM);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = st_reg.rdata;

  logic [23:0] e_q;
  logic [23:0] a_q;
  logic [23:0] sel_word;
  logic [23:0] imm_word;
  assign e_q = st_reg.gpr[`IAD_IDX_E];
  assign a_q = st_reg.gpr[`IAD_IDX_A];
  assign sel_word = sel_ok ? st_reg.gpr[sel_idx] : `IAD_RST_WORD;
  assign imm_word = {9'h000, st_reg.imm};

  // Multi-bit mask reduction, one slice per general register
  logic [`IAD_NUM_GPR-1:0][23:0] src_part;
  logic [`IAD_NUM_GPR-1:0][23:0] dst_part;
  logic [23:0] src_or;
  logic [23:0] dst_or;
  genvar gi;
  generate
    for (gi = 0; gi < `IAD_NUM_GPR; gi++)
    begin : g_mask
      assign src_part[gi] = c_src[gi] ? st_reg.gpr[gi] : `IAD_RST_WORD;
      assign dst_part[gi] = c_dst[gi] ? st_reg.gpr[gi] : `IAD_RST_WORD;
    end
  endgenerate
  always_comb
  begin
    src_or = `IAD_RST_WORD;
    dst_or = `IAD_RST_WORD;
    for (int i = 0; i < `IAD_NUM_GPR; i++)
    begin
      src_or = src_or | src_part[i];
      dst_or = dst_or | dst_part[i];
    end
  end

  // Divide: A23 dropped, E:A[22:0] over a sign-extended divisor
  logic is_div;
  logic div_ok;
  logic [23:0] div_src;
  logic signed [46:0] dvd;
  logic signed [46:0] dvs;
  logic signed [46:0] quo;
  logic signed [46:0] rem;
  logic div_ov;
  assign is_div = (c_op == iad_pkg::op_divide_by_mem) || (c_op == iad_pkg::op_divide_by_imm)
    || (c_op == iad_pkg::op_divide_by_index) || (c_op == iad_pkg::op_divide_by_t);
  assign div_ok = is_div && ((c_op != iad_pkg::op_divide_by_index) || (sel_ok && !c_sel[2]));
  assign div_src = (c_op == iad_pkg::op_divide_by_mem) ? st_reg.mem :
    (c_op == iad_pkg::op_divide_by_imm) ? imm_word :
    (c_op == iad_pkg::op_divide_by_t) ? st_reg.gpr[`IAD_IDX_T] : sel_word;
  assign dvd = $signed({e_q, a_q[22:0]});
  assign dvs = (div_src == `IAD_RST_WORD) ? 47'sd1 : $signed({{23{div_src[23]}}, div_src});
  // Quotient truncates toward zero, so the remainder follows the dividend sign
  assign quo = dvd / dvs;
  assign rem = dvd % dvs;
  // Quotient outside 24 bits is the general form of E not below the divisor
  assign div_ov = (div_src == `IAD_RST_WORD) || !((&quo[46:23]) || !(|quo[46:23]));

  // Multiply: signed A times the chosen operand
  logic [23:0] mul_src;
  logic mul_ok;
  logic signed [47:0] prod;
  assign mul_ok = (c_op == iad_pkg::op_multiply_by_mem) || (c_op == iad_pkg::op_multiply_by_imm)
    || ((c_op == iad_pkg::op_multiply_by_reg) && sel_ok);
  assign mul_src = (c_op == iad_pkg::op_multiply_by_mem) ? st_reg.mem :
    (c_op == iad_pkg::op_multiply_by_imm) ? imm_word : sel_word;
  assign prod = $signed(a_q) * $signed(mul_src);

  // Access violation seen in user mode
  logic viol;
  assign viol = st_reg.fault[`IAD_FLT_USER] && (st_reg.fault[`IAD_FLT_DEMAND]
    || st_reg.fault[`IAD_FLT_RESTRICT] || st_reg.fault[`IAD_FLT_LIMIT]);

  function automatic logic [24:0] add_ov(input logic [23:0] x, input logic [23:0] y);
    logic [23:0] s;
    s = x + y;
    // Carry into sign without carry out, or the reverse, is a sign mismatch
    return {(x[23] == y[23]) && (s[23] != x[23]), s};
  endfunction

  function automatic logic [1:0] cc_of(input logic neg, input logic zero);
    return neg ? `IAD_CC_NEG : (zero ? `IAD_CC_ZERO : `IAD_CC_POS);
  endfunction

  // Next-state of every register; writes are refused while a sequence runs
  always_comb
  begin
    logic [24:0] r;
    logic [46:0] d;
    logic [23:0] pe;
    r = 25'h0;
    d = 47'h0;
    pe = `IAD_RST_WORD;
    st_next = st_reg;
    if (psel && !penable)
    begin
      st_next.rdata = 32'h00000000;
      if (paddr < `IAD_OFF_MEM)
        st_next.rdata = {8'h00, st_reg.gpr[paddr[4:2]]};
      else if (paddr == `IAD_OFF_MEM)
        st_next.rdata = {8'h00, st_reg.mem};
      else if (paddr == `IAD_OFF_PC)
        st_next.rdata = {8'h00, st_reg.pc};
      else if (paddr == `IAD_OFF_STATUS)
        st_next.rdata = {27'h0000000, st_reg.pcdec, st_reg.ov, st_reg.cc, busy};
      else if (paddr == `IAD_OFF_FAULT)
        st_next.rdata = {28'h0000000, st_reg.fault};
      else if (paddr == `IAD_OFF_IMM)
        st_next.rdata = {17'h00000, st_reg.imm};
    end
    if (acc_wr)
    begin
      if (paddr < `IAD_OFF_MEM)
        st_next.gpr[paddr[4:2]] = pwdata[23:0];
      else if (paddr == `IAD_OFF_MEM)
        st_next.mem = pwdata[23:0];
      else if (paddr == `IAD_OFF_PC)
        st_next.pc = pwdata[23:0];
      else if (paddr == `IAD_OFF_FAULT)
        st_next.fault = pwdata[3:0];
      else if (paddr == `IAD_OFF_IMM)
        st_next.imm = pwdata[14:0];
      else if (paddr == `IAD_OFF_STATUS)
      begin
        st_next.ov = pwdata[`IAD_ST_OV];
        st_next.pcdec = st_reg.pcdec && !pwdata[`IAD_ST_PCDEC];
      end
    end
    // Command start; unnamed registers keep their values
    if (go)
    begin
      unique case (c_op)
        iad_pkg::op_add_imm_to_reg:
          if (sel_ok)
          begin
            r = add_ov(sel_word, imm_word);
            st_next.gpr[sel_idx] = r[23:0];
            st_next.cc = cc_of(r[23], r[23:0] == `IAD_RST_WORD);
            st_next.ov = st_reg.ov | r[24];
          end
        iad_pkg::op_add_imm_to_mem:
          if (viol)
          begin
            st_next.pc = st_reg.pc - 24'h000001;
            st_next.pcdec = 1'b1;
          end
          else
          begin
            r = add_ov(st_reg.mem, {{16{c_cnt[7]}}, c_cnt});
            st_next.mem = r[23:0];
            st_next.cc = cc_of(r[23], r[23:0] == `IAD_RST_WORD);
            st_next.ov = st_reg.ov | r[24];
          end
        iad_pkg::op_add_reg_to_reg:
        begin
          r = add_ov(src_or, dst_or);
          for (int i = 0; i < `IAD_NUM_GPR; i++)
            if (c_dst[i])
              st_next.gpr[i] = r[23:0];
          st_next.cc = cc_of(r[23], r[23:0] == `IAD_RST_WORD);
          st_next.ov = st_reg.ov | r[24];
        end
        iad_pkg::op_divide_by_mem, iad_pkg::op_divide_by_imm,
        iad_pkg::op_divide_by_index, iad_pkg::op_divide_by_t:
          if (div_ok)
          begin
            st_next.gpr[`IAD_IDX_A] = {1'b0, a_q[22:0]};
            if (div_ov)
            begin
              st_next.ov = 1'b1;
              st_next.cc = cc_of(1'b0, a_q[22:0] == 23'h000000);
            end
            else
            begin
              st_next.gpr[`IAD_IDX_A] = quo[23:0];
              st_next.gpr[`IAD_IDX_E] = rem[23:0];
              st_next.cc = cc_of(quo[23], quo[23:0] == `IAD_RST_WORD);
            end
          end
        iad_pkg::op_poly_divide:
        begin
          st_next.steps = (c_cnt == 8'h00) ? 8'h01 : c_cnt;
          st_next.fsm = iad_pkg::fsm_poly;
        end
        iad_pkg::op_sign_extend_a:
        begin
          st_next.gpr[`IAD_IDX_E] = {24{a_q[23]}};
          st_next.gpr[`IAD_IDX_A] = {1'b0, a_q[22:0]};
          st_next.cc = cc_of(a_q[23], a_q == `IAD_RST_WORD);
        end
        iad_pkg::op_sign_extend_byte:
        begin
          pe = {{16{a_q[7]}}, a_q[7:0]};
          st_next.gpr[`IAD_IDX_A] = pe;
          st_next.cc = cc_of(pe[23], pe == `IAD_RST_WORD);
        end
        iad_pkg::op_float_normalize:
        begin
          d = {e_q, a_q[22:0]};
          if (st_reg.ov)
          begin
            d = {~e_q[23], d[46:1]};
            st_next.gpr[`IAD_IDX_I] = 24'h000001;
          end
          else if (d == 47'h0)
            st_next.gpr[`IAD_IDX_I] = `IAD_NORM_ZERO_COUNT;
          else if (e_q == `IAD_FULL_NEG && a_q[22:0] == 23'h000000)
          begin
            d = {1'b1, d[46:1]};
            st_next.gpr[`IAD_IDX_I] = 24'h000001;
          end
          else
          begin
            st_next.nshift = `IAD_RST_WORD;
            st_next.fsm = iad_pkg::fsm_norm;
          end
          st_next.gpr[`IAD_IDX_E] = d[46:23];
          st_next.gpr[`IAD_IDX_A] = {1'b0, d[22:0]};
          st_next.cc = cc_of(d[46], d == 47'h0);
        end
        iad_pkg::op_multiply_by_mem, iad_pkg::op_multiply_by_imm,
        iad_pkg::op_multiply_by_reg:
          if (mul_ok)
          begin
            st_next.gpr[`IAD_IDX_E] = prod[46:23];
            st_next.gpr[`IAD_IDX_A] = {1'b0, prod[22:0]};
            st_next.cc = cc_of(prod[46], prod[46:0] == 47'h0);
            // Only the square of full-scale negative escapes 47 bits
            if (a_q == `IAD_FULL_NEG && mul_src == `IAD_FULL_NEG)
              st_next.ov = 1'b1;
          end
        default:
          st_next.cc = st_reg.cc;
      endcase
    end
    // Multi-cycle sequences, one shift per clock
    unique case (st_reg.fsm)
      iad_pkg::fsm_idle:
        st_next.steps = st_next.steps;
      iad_pkg::fsm_poly:
      begin
        pe = {e_q[22:0], 1'b0};
        st_next.gpr[`IAD_IDX_E] = e_q[23] ? (pe ^ a_q) : pe;
        st_next.steps = st_reg.steps - 8'h01;
        if (st_reg.steps == 8'h01)
          st_next.fsm = iad_pkg::fsm_idle;
      end
      iad_pkg::fsm_norm:
      begin
        d = {e_q, a_q[22:0]};
        if ((e_q[23] != e_q[22]) || (e_q == `IAD_NORM_STOP && a_q[22:0] == 23'h000000))
        begin
          st_next.gpr[`IAD_IDX_I] = st_reg.nshift;
          st_next.cc = cc_of(e_q[23], 1'b0);
          st_next.fsm = iad_pkg::fsm_idle;
        end
        else
        begin
          d = {d[45:0], 1'b0};
          st_next.gpr[`IAD_IDX_E] = d[46:23];
          st_next.gpr[`IAD_IDX_A] = {1'b0, d[22:0]};
          st_next.nshift = st_reg.nshift - 24'h000001;
        end
      end
      default:
        st_next.fsm = iad_pkg::fsm_idle;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ADD_IMM_REG: assert property (
    go && c_op == iad_pkg::op_add_imm_to_reg && sel_ok |=>
      st_reg.gpr[$past(sel_idx)] == 24'($past(sel_word) + $past(imm_word)))
    else $error("immediate add result wrong");
  AST_ADD_OV: assert property (
    go && c_op == iad_pkg::op_add_imm_to_mem && !viol && st_reg.mem == `IAD_FULL_NEG
      && c_cnt == 8'h80 |=> st_reg.ov && st_reg.cc == `IAD_CC_POS)
    else $error("memory add overflow missed");
  AST_PC_DEC: assert property (
    go && c_op == iad_pkg::op_add_imm_to_mem && viol |=>
      st_reg.pc == 24'($past(st_reg.pc) - 24'h000001) && $stable(st_reg.mem))
    else $error("violation did not back up pc");
  AST_RR_KEEP: assert property (
    go && c_op == iad_pkg::op_add_reg_to_reg && !c_dst[0] |=> $stable(st_reg.gpr[0]))
    else $error("unflagged register changed");
  AST_DIV_REM: assert property (
    go && div_ok && !div_ov |=>
      st_reg.gpr[`IAD_IDX_E] == 24'h0 || st_reg.gpr[`IAD_IDX_E][23] == $past(e_q[23]))
    else $error("remainder sign wrong");
  AST_DIV_OV: assert property (
    go && div_ok && !e_q[23] && !div_src[23] && e_q >= div_src |=> st_reg.ov)
    else $error("divide overflow missed");
  AST_POLY_ZERO: assert property (
    go && c_op == iad_pkg::op_poly_divide && c_cnt == 8'h00 |=>
      st_reg.fsm == iad_pkg::fsm_poly ##1 st_reg.fsm == iad_pkg::fsm_idle && $stable(a_q))
    else $error("zero count not one step");
  AST_SEXT_A: assert property (
    go && c_op == iad_pkg::op_sign_extend_a |=>
      e_q == {24{$past(a_q[23])}} && !a_q[23])
    else $error("sign extend of A wrong");
  AST_NORM_ZERO: assert property (
    go && c_op == iad_pkg::op_float_normalize && !st_reg.ov && e_q == 24'h0
      && a_q[22:0] == 23'h0 |=> st_reg.gpr[`IAD_IDX_I] == `IAD_NORM_ZERO_COUNT)
    else $error("zero normalize count wrong");
  AST_MUL_OV: assert property (
    go && mul_ok && a_q == `IAD_FULL_NEG && mul_src == `IAD_FULL_NEG |=>
      st_reg.ov && e_q == `IAD_FULL_NEG)
    else $error("full-scale multiply overflow missed");
endmodule

/* verification/iad_fetch_model.sv */
// Decoder and operand fetch stand-in: an APB master on pclk.
// Assumes tb calls xfer and owns fail_count and conclude for a hung slave.
`timescale 1ns/1ps
module iad_fetch_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial
  begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
  end

  // One transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
        @(posedge pclk);
        if (pready === 1'b1)
          break;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;  // Stale data must not look valid
      if (n == 16)
      begin
        tb.fail_count++;
        tb.conclude();
      end
    end
  endtask
endmodule

/* verification/tb.sv */
// Self-checking bench of the arithmetic datapath over APB.
// Assumes iad_fetch_model as bus master; expectations come from local functions.
`timescale 1ns/1ps
`include "iad_defines.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fail_count, n_tests;
  localparam logic [7:0] ST = `IAD_OFF_STATUS;
  localparam logic [7:0] MEM = `IAD_OFF_MEM;
  localparam logic [7:0] IMM = `IAD_OFF_IMM;
  iad_pkg::iad_op_t dop [6] = '{iad_pkg::op_divide_by_imm, iad_pkg::op_divide_by_index,
    iad_pkg::op_divide_by_index, iad_pkg::op_divide_by_index, iad_pkg::op_divide_by_t,
    iad_pkg::op_divide_by_mem};

  iad_datapath u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  iad_fetch_model u_fetch (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Count one comparison, report a mismatch
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Verdict, single end of run
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Register access helpers, 24-bit value in the low bits
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    u_fetch.xfer(1'b1, a, {8'h00, d}, q, e);
  endtask
  task automatic rb(input logic [7:0] a);
    u_fetch.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [23:0] x);
    rb(a);
    chk(nm, q, {8'h00, x});
  endtask
  task automatic st(input logic [1:0] c, input logic o, input logic p);
    rc("status", ST, {19'h0, p, o, c, 1'b0});
  endtask

  // Status preset, command, then bounded busy poll
  task automatic run(input logic [31:0] c, input logic [23:0] sv);
    int n;
    begin
      wr(ST, sv);
      u_fetch.xfer(1'b1, `IAD_OFF_CMD, c, q, e);
      for (n = 0; n < 40; n++)
      begin
        rb(ST);
        if (q[`IAD_ST_BUSY] === 1'b0)
          break;
      end
      if (n == 40)
      begin
        fail_count++;
        conclude();
      end
    end
  endtask

  function automatic logic [1:0] ccf(input logic [23:0] v);
    return (v == 24'h0) ? `IAD_CC_ZERO : (v[23] ? `IAD_CC_NEG : `IAD_CC_POS);
  endfunction
  function automatic logic [31:0] cmd(input logic [3:0] op, input logic [2:0] s,
    input logic [7:0] n, input logic [5:0] sm, input logic [5:0] dm);
    return {2'b00, dm, 2'b00, sm, n, 1'b0, s, op};
  endfunction
  function automatic logic [7:0] ga(input int s);
    return 8'(4 * (s - 1));
  endfunction
  // Modulo-2 division, one step per shift
  function automatic logic [23:0] pdiv(input logic [23:0] x, input logic [23:0] a,
    input int n);
    for (int i = 0; i < ((n == 0) ? 1 : n); i++)
      x = x[23] ? ((x << 1) ^ a) : (x << 1);
    return x;
  endfunction
  // Normalize result as {count, E, A}
  function automatic logic [71:0] nrm(input logic [23:0] ev, input logic [23:0] av,
    input logic ov);
    logic [46:0] d;
    logic [23:0] c;
    d = {ev, av[22:0]};
    c = 24'h0;
    if (ov)
    begin
      d = {~d[46], d[46:1]};
      c = 24'h000001;
    end
    else if (d == 47'h0)
      c = `IAD_NORM_ZERO_COUNT;
    else if (d == {1'b1, 46'h0})
    begin
      d = {2'b11, 45'h0};
      c = 24'h000001;
    end
    else
      while (d[46] == d[45] && d != {2'b11, 45'h0})
      begin
        d = d << 1;
        c = c - 24'h1;
      end
    return {c, d[46:23], 1'b0, d[22:0]};
  endfunction

  initial
  begin
    logic [23:0] v, w, x, r, ea, aa;
    logic [23:0] g [1:6];
    logic [14:0] im;
    logic [7:0] nb;
    logic signed [47:0] dd, dv, qq, rr;
    logic [71:0] z;
    void'($urandom(79943));
    presetn = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rc("rst_a", ga(5), `IAD_RST_WORD);
    // Immediate into each register, last one overflowing
    for (int s = 1; s <= 6; s++)
    begin
      v = (s == 6) ? 24'h7FFFFF : 24'($urandom);
      im = 15'($urandom) | 15'h1;
      wr(ga(s), v);
      wr(IMM, {9'h0, im});
      run(cmd(iad_pkg::op_add_imm_to_reg, 3'(s), 8'h0, 6'h0, 6'h0), 24'h10);
      r = v + {9'h0, im};
      rc("add_reg", ga(s), r);
      st(ccf(r), ~v[23] & r[23], 1'b0);
    end
    // Signed byte into memory word, first case overflows
    for (int k = 0; k < 3; k++)
    begin
      v = (k == 0) ? `IAD_FULL_NEG : 24'($urandom);
      nb = (k == 0) ? 8'h80 : 8'($urandom);
      r = v + {{16{nb[7]}}, nb};
      wr(MEM, v);
      run(cmd(iad_pkg::op_add_imm_to_mem, 3'h1, nb, 6'h0, 6'h0), 24'h10);
      rc("add_mem", MEM, r);
      st(ccf(r), (v[23] == nb[7]) && (r[23] != v[23]), 1'b0);
    end
    // Each user-mode violation backs up the program counter
    for (int f = 0; f < 3; f++)
    begin
      v = 24'($urandom);
      w = 24'($urandom);
      wr(MEM, v);
      wr(`IAD_OFF_PC, w);
      wr(`IAD_OFF_FAULT, 24'(8 | (1 << f)));
      run(cmd(iad_pkg::op_add_imm_to_mem, 3'h1, 8'h05, 6'h0, 6'h0), 24'h10);
      rc("pc", `IAD_OFF_PC, w - 24'h1);
      rc("mem_kept", MEM, v);
      rb(ST);
      chk("pcdec", 32'(q[`IAD_ST_PCDEC]), 32'h1);
      wr(ST, 24'h10);
      rb(ST);
      chk("pcdec", 32'(q[`IAD_ST_PCDEC]), 32'h0);
    end
    wr(`IAD_OFF_FAULT, 24'h0);
    // Masked add: two sources into two targets, then empty masks
    for (int s = 1; s <= 6; s++)
    begin
      g[s] = 24'($urandom);
      wr(ga(s), g[s]);
    end
    for (int p = 0; p < 2; p++)
    begin
      x = p ? 24'h0 : g[1] | g[2];
      w = p ? 24'h0 : g[4] | g[6];
      r = x + w;
      run(cmd(iad_pkg::op_add_reg_to_reg, 3'h1, 8'h0, p ? 6'h0 : 6'h03,
        p ? 6'h0 : 6'h28), 24'h10);
      if (p == 0)
      begin
        g[4] = r;
        g[6] = r;
        st(ccf(r), (x[23] == w[23]) && (r[23] != x[23]), 1'b0);
      end
      for (int s = 1; s <= 6; s++)
        rc("reg_add", ga(s), g[s]);
    end
    // Divide by each source: plain, negative dividend, overflow
    for (int k = 0; k < 6; k++)
      for (int j = 0; j < 3; j++)
      begin
        dv = 48'($urandom_range(32767, 2));
        ea = (j == 0) ? 24'($urandom) % dv[23:0] : ((j == 1) ? 24'hFFFFFF : dv[23:0]);
        aa = 24'($urandom);
        wr(k == 0 ? IMM : (k == 5 ? MEM : ga(k == 4 ? 6 : k)), dv[23:0]);
        wr(ga(4), ea);
        wr(ga(5), aa);
        run(cmd(dop[k], 3'((k >= 1 && k <= 3) ? k : 1), 8'h0, 6'h0, 6'h0), 24'h10);
        dd = {ea[23], ea, aa[22:0]};
        qq = dd / dv;
        rr = dd % dv;
        if (j == 2)
        begin
          rc("div_e", ga(4), ea);
          rc("div_a", ga(5), aa & 24'h7FFFFF);
          st(ccf(aa & 24'h7FFFFF), 1'b1, 1'b0);
        end
        else
        begin
          rc("div_e", ga(4), rr[23:0]);
          if (j == 0)
            rc("div_a", ga(5), qq[23:0]);
          st(ccf(qq[23:0]), 1'b0, 1'b0);
        end
      end
    // Polynomial divide, counts 0, 1, 2 and a random even one
    for (int k = 0; k < 4; k++)
    begin
      nb = (k < 3) ? 8'(k) : 8'($urandom_range(24, 4)) & 8'hFE;
      ea = 24'($urandom);
      aa = 24'($urandom) | `IAD_FULL_NEG;
      wr(ga(4), ea);
      wr(ga(5), aa);
      run(cmd(iad_pkg::op_poly_divide, 3'h1, nb, 6'h0, 6'h0), 24'h10);
      rc("poly_e", ga(4), pdiv(ea, aa, int'(nb)));
      rc("poly_a", ga(5), aa);
    end
    // Sign extensions with both sign values
    for (int k = 0; k < 2; k++)
    begin
      aa = {k[0], 23'($urandom)};
      wr(ga(5), aa);
      run(cmd(iad_pkg::op_sign_extend_a, 3'h1, 8'h0, 6'h0, 6'h0), 24'h10);
      rc("esa_e", ga(4), {24{aa[23]}});
      rc("esa_a", ga(5), {1'b0, aa[22:0]});
      aa = {16'($urandom), k[0], 7'($urandom)};
      wr(ga(5), aa);
      run(cmd(iad_pkg::op_sign_extend_byte, 3'h1, 8'h0, 6'h0, 6'h0), 24'h10);
      r = {{16{aa[7]}}, aa[7:0]};
      rc("esb", ga(5), r);
      st(ccf(r), 1'b0, 1'b0);
    end
    // Normalize: zero, invalid pattern, long shift, random, overflow preset
    for (int k = 0; k < 5; k++)
    begin
      ea = (k == 1) ? `IAD_FULL_NEG : ((k == 0 || k == 2) ? 24'h0 : 24'($urandom));
      aa = (k < 2) ? 24'h0 : 24'($urandom);
      wr(ga(4), ea);
      wr(ga(5), aa);
      run(cmd(iad_pkg::op_float_normalize, 3'h1, 8'h0, 6'h0, 6'h0), k == 4 ? 24'h18 : 24'h10);
      z = nrm(ea, aa, k == 4);
      rc("fn_i", ga(1), z[71:48]);
      rc("fn_e", ga(4), z[47:24]);
      rc("fn_a", ga(5), z[23:0]);
    end
    // Multiply by each source, last case full-scale negative squared
    for (int k = 0; k < 9; k++)
    begin
      aa = (k == 8) ? `IAD_FULL_NEG : 24'($urandom);
      v = (k == 0) ? {9'h0, 15'($urandom)} : ((k == 8) ? `IAD_FULL_NEG : 24'($urandom));
      v = (k == 6) ? aa : v;
      wr(k == 0 ? IMM : ((k == 1 || k == 8) ? MEM : ga(k - 1)), v);
      wr(ga(5), aa);
      run(cmd(k == 0 ? iad_pkg::op_multiply_by_imm : ((k == 1 || k == 8) ?
        iad_pkg::op_multiply_by_mem : iad_pkg::op_multiply_by_reg),
        3'((k < 2 || k == 8) ? 1 : k - 1), 8'h0, 6'h0, 6'h0), 24'h10);
      dd = $signed({{24{aa[23]}}, aa}) * $signed({{24{v[23]}}, v});
      rc("mul_e", ga(4), dd[46:23]);
      rc("mul_a", ga(5), {1'b0, dd[22:0]});
      rb(ST);
      chk("mul_ov", 32'(q[`IAD_ST_OV]), 32'(k == 8));
    end
    // Unmapped write refused, memory word untouched
    u_fetch.xfer(1'b1, 8'h30, 32'h00FFFFFF, q, e);
    chk("unmapped", 32'(e), 32'h1);
    rc("kept_mem", MEM, `IAD_FULL_NEG);
    conclude();
  end
endmodule
